// File: bench/flac_assertions.sv
// Checker on the APB port of the command engine
`include "flac_defs.svh"
module flac_assertions (
  input wire logic CLK_SYS,
  input wire logic RST,
  input wire logic PSEL,
  input wire logic PENABLE,
  input wire logic PWRITE,
  input wire logic [7:0] PADDR,
  input wire logic [31:0] PWDATA,
  input wire logic [31:0] PRDATA,
  input wire logic PREADY,
  input wire logic PSLVERR
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking cb @(posedge CLK_SYS); endclocking
  default disable iff (RST);
  logic st_rd;
  // Completed status read
  assign st_rd = PREADY && !PWRITE && PADDR == `FLAC_OFS_STAT;
  property p_wait; PSEL && PENABLE && !PREADY |=> PREADY; endproperty
  a_wait: assert property (p_wait) else $error("ready late");
  property p_one; PREADY |=> !PREADY; endproperty
  a_one: assert property (p_one) else $error("ready too long");
  property p_setup; PSEL && !PENABLE |-> !PREADY; endproperty
  a_setup: assert property (p_setup) else $error("ready in setup");
  property p_past; PREADY |-> $past(PSEL && PENABLE) && $past(PSEL, 2); endproperty
  a_past: assert property (p_past) else $error("ready without access");
  property p_err; PREADY && PADDR[1:0] == 2'b00 |-> PSLVERR == (PADDR > `FLAC_OFS_CUR); endproperty
  a_err: assert property (p_err) else $error("wrong slave error");
  property p_idle0; !PREADY |-> PRDATA == 32'h0; endproperty
  a_idle0: assert property (p_idle0) else $error("read data outside answer");
  property p_rx;
    st_rd && PRDATA[18:16] == 3'd1 |-> PRDATA[31] && PRDATA[15:0] == `FLAC_SW_PENDING;
  endproperty
  a_rx: assert property (p_rx) else $error("pending block status wrong");
  property p_state; st_rd |-> PRDATA[18:16] <= 3'd4; endproperty
  a_state: assert property (p_state) else $error("chain state out of range");
  c_done: cover property (st_rd && PRDATA[15:0] == `FLAC_SW_DATA_DONE);
  c_more: cover property (st_rd && PRDATA[15:0] == `FLAC_SW_MORE_RESP);
  c_err: cover property (PSLVERR);
endmodule // flac_assertions

bind flac_core flac_assertions flac_assertions_i (.CLK_SYS(CLK_SYS), .RST(RST), .PSEL(PSEL),
  .PENABLE(PENABLE), .PWRITE(PWRITE), .PADDR(PADDR), .PWDATA(PWDATA), .PRDATA(PRDATA),
  .PREADY(PREADY), .PSLVERR(PSLVERR));

// File: bench/flac_term.sv
// Terminal side model: APB master issuing command words
module flac_term (
  input wire logic clk,
  input wire logic pready,
  input wire logic [31:0] prdata,
  input wire logic pslverr,
  output logic psel,
  output logic penable,
  output logic pwrite,
  output logic [7:0] paddr,
  output logic [31:0] pwdata
);
  timeunit 1ns;
  timeprecision 1ps;
  // Idle bus, driven once before reset release
  task automatic bus_idle();
    psel <= 1'b0;
    penable <= 1'b0;
    pwrite <= 1'b0;
    paddr <= 8'h00;
    pwdata <= 32'h0;
  endtask
  // One transfer, held until ready is sampled
  task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d,
                      output logic [31:0] q, output logic e);
    @(posedge clk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    // Wait for ready; only the bench watchdog ends a hang
    do begin
      @(posedge clk);
    end while (pready !== 1'b1);
    q = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    pwdata <= ~d; // Stale data not left on the bus
  endtask
endmodule // flac_term

// File: bench/tb.sv
// Self-checking bench for the command engine
`include "flac_defs.svh"
module tb import flac_pkg::*;;
  timeunit 1ns;
  timeprecision 1ps;
  localparam logic [7:0] KEY = 8'h5a;
  logic CLK_SYS, RST, psel, penable, pwrite, pready, pslverr, odd, cur_v;
  logic [7:0] paddr, rs;
  logic [31:0] pwdata, prdata, q;
  logic [15:0] flv, cur, f, g;
  logic [7:0] ch[$], d[$], sel[3], tg[2];
  int n_fail, checks_done;
  flac_core #(.SECRET(KEY)) flac_core_i (.CLK_SYS(CLK_SYS), .RST(RST), .PSEL(psel),
    .PENABLE(penable), .PWRITE(pwrite), .PADDR(paddr), .PWDATA(pwdata), .PRDATA(prdata),
    .PREADY(pready), .PSLVERR(pslverr));
  flac_term flac_term_i (.clk(CLK_SYS), .pready(pready), .prdata(prdata), .pslverr(pslverr),
    .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata));
  // Free running clock
  initial begin
    CLK_SYS = 1'b0;
    forever #4 CLK_SYS = ~CLK_SYS;
  end
  task automatic test_done();
    $display("counts: %0d checks, %0d mismatches", checks_done, n_fail);
    if (n_fail == 0 && checks_done > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask
  task automatic chk(input logic [31:0] s, input logic [31:0] x);
    checks_done++;
    if (s !== x) begin
      n_fail++;
      $display("mismatch at %0t: saw %h want %h", $time, s, x);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] dv);
    logic [31:0] r;
    logic e;
    flac_term_i.xfer(1'b1, a, dv, r, e);
  endtask
  task automatic rd(input logic [7:0] a, output logic [31:0] r);
    logic e;
    flac_term_i.xfer(1'b0, a, 32'h0, r, e);
  endtask
  task automatic cmd(input flac_op_t op, input logic [7:0] p1, p2, ln, input logic fs);
    flac_ctrl_t c;
    c = '{spare: 4'h0, final_seg: fs, op: op, len: ln, p2: p2, p1: p1};
    wr(`FLAC_OFS_CTRL, c);
  endtask
  task automatic sw(input logic [15:0] x);
    logic [31:0] r;
    rd(`FLAC_OFS_STAT, r);
    chk({16'h0, r[15:0]}, {16'h0, x});
  endtask
  // Current file id and its flag against the model
  task automatic cc();
    logic [31:0] r;
    rd(`FLAC_OFS_CUR, r);
    chk({14'h0, r[31:30], r[15:0]}, {14'h0, cur_v, flv[cur[3:0]], cur});
  endtask
  task automatic dblk(input flac_op_t op, input logic [7:0] p1, input logic fs);
    logic [31:0] r;
    logic [31:0] x;
    cmd(op, p1, 8'h00, 8'(d.size()), fs);
    // Block open: receiving, bytes left, pending status
    rd(`FLAC_OFS_STAT, r);
    x = {1'b1, 4'h0, 8'(d.size()), FLAC_ST_RX, `FLAC_SW_PENDING};
    chk({r[31], 4'h0, r[26:0]}, x);
    foreach (d[i]) wr(`FLAC_OFS_DIN, {24'h0, d[i]});
  endtask
  task automatic rsp(input int i0, input int n);
    logic [31:0] r;
    for (int i = i0; i < i0 + n; i++) begin
      rd(`FLAC_OFS_DOUT, r);
      chk(r, {24'h0, (odd && i < `FLAC_TLV_HDR) ? ch[i] : ch[i] ^ KEY});
    end
  endtask
  function automatic logic [7:0] rb();
    return 8'($urandom_range(255));
  endfunction
  // Block role with random algorithm bits
  function automatic logic [7:0] rp(input logic [2:0] r);
    return {r, 5'($urandom_range(31))};
  endfunction
  // Hang guard
  initial begin
    #100000;
    n_fail++;
    test_done();
  end
  initial begin
    RST = 1'b1;
    flac_term_i.bus_idle();
    n_fail = 0;
    checks_done = 0;
    flv = 16'hffff;
    cur = 16'h0;
    cur_v = 1'b0;
    sel = '{`FLAC_P1_BY_ID, `FLAC_P1_PATH_MF, `FLAC_P1_PATH_DF};
    tg = '{`FLAC_TAG_BER, `FLAC_TAG_OTHER};
    void'($urandom(32'h942a54a8));
    repeat (6) @(posedge CLK_SYS);
    RST <= 1'b0;
    sw(`FLAC_SW_RESET);
    rd(`FLAC_OFS_CUR, q);
    chk({31'h0, q[31]}, 32'h0);
    rd(8'h20, q);
    chk(q, 32'h0);
    cmd(FLAC_OP_DEACT, `FLAC_P1_BY_ID, `FLAC_P2_NONE, `FLAC_LEN_NONE, 1'b0);
    sw(`FLAC_SW_SEQ);
    cc();
    $display("test reset done");
    foreach (sel[i]) begin
      f = 16'($urandom_range(65535));
      g = 16'($urandom_range(65535));
      wr(`FLAC_OFS_FILE, {15'h0, 1'b1, f});
      cmd(FLAC_OP_DEACT, sel[i], `FLAC_P2_NONE, 8'h02, 1'b0);
      flv[f[3:0]] = 1'b0;
      cur = f;
      cur_v = 1'b1;
      sw(`FLAC_SW_OK);
      cc();
      cmd(FLAC_OP_FILE_USE, 8'h00, 8'h00, 8'h00, 1'b0);
      sw(`FLAC_SW_INVALID);
      wr(`FLAC_OFS_FILE, {15'h0, 1'b1, g});
      cmd(FLAC_OP_ACT, `FLAC_P1_BY_ID, `FLAC_P2_NONE, `FLAC_LEN_NONE, 1'b0);
      flv[f[3:0]] = 1'b1;
      sw(`FLAC_SW_OK);
      cc();
      wr(`FLAC_OFS_FILE, {15'h0, 1'b0, g});
      cmd(FLAC_OP_ACT, sel[i], `FLAC_P2_NONE, 8'h02, 1'b0);
      sw(`FLAC_SW_NO_AC);
      cc();
      do rs = rb(); while (rs == 8'h00 || rs == 8'h08 || rs == 8'h09);
      cmd(FLAC_OP_ACT, rs, `FLAC_P2_NONE, 8'h02, 1'b0);
      sw(`FLAC_SW_BAD_P1P2);
      cc();
      do rs = rb(); while (rs == `FLAC_P2_NONE);
      cmd(FLAC_OP_ACT, sel[i], rs, 8'h02, 1'b0);
      sw(`FLAC_SW_BAD_P1P2);
      cc();
      wr(`FLAC_OFS_FILE, {15'h0, 1'b1, g});
      cmd(FLAC_OP_ACT, sel[i], `FLAC_P2_NONE, 8'h02, 1'b0);
      flv[g[3:0]] = 1'b1;
      cur = g;
      sw(`FLAC_SW_OK);
      cc();
    end
    $display("test file lifecycle done");
    odd = 1'b1;
    foreach (tg[t]) begin
      cmd(FLAC_OP_AUTH_ODD, rp(`FLAC_ROLE_DNEXT), 8'h00, 8'h01, 1'b0);
      sw(`FLAC_SW_SEQ);
      d = {tg[t], rb(), rb()};
      ch = d;
      dblk(FLAC_OP_AUTH_ODD, rp(`FLAC_ROLE_DFIRST), 1'b0);
      sw(`FLAC_SW_MORE_DATA);
      d = {rb(), rb()};
      dblk(FLAC_OP_AUTH_ODD, rp(`FLAC_ROLE_DNEXT), 1'b1);
      sw(`FLAC_SW_DATA_DONE);
      d = {rb(), rb()};
      ch = {ch[0:2], d};
      dblk(FLAC_OP_AUTH_ODD, rp(`FLAC_ROLE_DRETX), 1'b1);
      sw(`FLAC_SW_DATA_DONE);
      cmd(FLAC_OP_AUTH_ODD, rp(`FLAC_ROLE_RFIRST), 8'h00, 8'h03, 1'b0);
      sw(`FLAC_SW_MORE_RESP);
      rsp(0, 3);
      cmd(FLAC_OP_AUTH_ODD, rp(`FLAC_ROLE_RRETX), 8'h00, 8'h03, 1'b0);
      sw(`FLAC_SW_MORE_RESP);
      rsp(0, 3);
      cmd(FLAC_OP_AUTH_ODD, rp(`FLAC_ROLE_RNEXT), 8'h00, 8'h02, 1'b0);
      sw(`FLAC_SW_OK);
      rsp(3, 2);
    end
    cmd(FLAC_OP_AUTH_ODD, rp(3'b110), 8'h00, 8'h01, 1'b1);
    sw(`FLAC_SW_BAD_P1P2);
    cmd(FLAC_OP_AUTH_ODD, rp(`FLAC_ROLE_DFIRST), 8'h00, 8'h00, 1'b1);
    sw(`FLAC_SW_BAD_LEN);
    d = {8'h11};
    dblk(FLAC_OP_AUTH_ODD, rp(`FLAC_ROLE_DFIRST), 1'b1);
    sw(`FLAC_SW_BAD_TLV);
    cmd(FLAC_OP_AUTH_ODD, rp(`FLAC_ROLE_RRETX), 8'h00, 8'h01, 1'b0);
    sw(`FLAC_SW_SEQ);
    $display("test odd chain done");
    odd = 1'b0;
    cmd(FLAC_OP_AUTH_EVEN, 8'h01, 8'h00, 8'h01, 1'b0);
    sw(`FLAC_SW_BAD_P1P2);
    d = {rb(), rb()};
    ch = d;
    dblk(FLAC_OP_AUTH_EVEN, `FLAC_P1_EVEN, 1'b0);
    sw(`FLAC_SW_OK);
    rsp(0, 2);
    cmd(flac_op_t'(3'd5), 8'h00, 8'h00, 8'h00, 1'b0);
    sw(`FLAC_SW_BAD_INS);
    $display("test even form done");
    test_done();
  end
endmodule // tb

// File: rtl/flac_buf.sv
// Byte buffer with registered read data for authentication data
module flac_buf #(
  parameter int DW = 8,
  parameter int AW = 10
) (
  input wire logic clk,
  input wire logic we,
  input wire logic [AW-1:0] waddr,
  input wire logic [DW-1:0] wdata,
  input wire logic [AW-1:0] raddr,
  output logic [DW-1:0] rdata_q
);
  logic [DW-1:0] mem [0:(1<<AW)-1];

  // Write port
  always_ff @(posedge clk) begin
    if (we) begin
      mem[waddr] <= wdata;
    end
  end

  // Registered read port
  always_ff @(posedge clk) begin
    rdata_q <= mem[raddr];
  end
endmodule // flac_buf

// File: rtl/flac_core.sv
// APB command engine for file lifecycle and chained authenticate
`include "flac_defs.svh"

// How it works
// - P1 00 selects by file id, 08 path from master, 09 path from dedicated.
// - P1 and P2 zero with no data act on the current file.
// - Activate returns a deactivated file to the active state.
// - Activate updates the file's lifecycle status flag.
// - Activate happens only when its access condition is met.
// - Successful activate makes the addressed file current.
// - Failed activate leaves current files unchanged.
// - Activate uses the same P1 selection coding as deactivate.
// - Odd code carries TLV wrapped data of up to 1024 bytes, the size of the buffer.
// - Odd data wrapped in tag 73 or tag 53.
// - Blocks of at most 255 bytes, P1 marks first or next.
// - Card joins data segments in arrival order.
// - Outstanding data segments answer 63 F1.
// - Final data segment answers 62 F3.
// - First response request runs the computation.
// - Card splits the response into ordered segments.
// - Remaining response segments answer 62 F1.
// - Final response segment answers 90 00.
// - Retransmit request resends the previous data or response block.
// - Deactivated current file refuses the file use command; authenticate does not check it.
// - P1 top bits give block role, low five bits algorithm.
module flac_core import flac_pkg::*; #(
  parameter int IDX_W = 4,
  parameter int BUF_AW = 10,
  parameter logic [7:0] SECRET = 8'h5a
) (
  input wire logic CLK_SYS,
  input wire logic RST,
  input wire logic PSEL,
  input wire logic PENABLE,
  input wire logic PWRITE,
  input wire logic [7:0] PADDR,
  input wire logic [31:0] PWDATA,
  output logic [31:0] PRDATA,
  output logic PREADY,
  output logic PSLVERR
);
  localparam int NF = 1 << IDX_W;
  localparam int PW = BUF_AW + 1;

  logic pready_q;
  logic pslverr_q;
  logic [31:0] prdata_q;
  logic access;
  logic wr_fire;
  logic rd_fire;
  logic ctrl_fire;
  logic din_fire;
  logic dout_fire;
  logic mapped;
  flac_ctrl_t c;
  flac_ctrl_t ctrl_q;
  flac_file_t file_q;
  logic [2:0] role;
  logic [PW-1:0] len_ext;
  logic [15:0] cur_ef_q;
  logic cur_valid_q;
  logic [NF-1:0] active_q;
  logic sel_ok;
  logic use_cur;
  logic [15:0] tgt;
  logic file_go;
  logic is_odd;
  logic ok_dfirst;
  logic ok_dnext;
  logic ok_dretx;
  logic ok_rfirst;
  logic ok_rnext;
  logic ok_rretx;
  logic ok_even;
  flac_state_t state_q;
  logic [PW-1:0] wptr_q;
  logic [PW-1:0] seg_start_q;
  logic [PW-1:0] total_q;
  logic [PW-1:0] rptr_q;
  logic [PW-1:0] rseg_start_q;
  logic [PW-1:0] rseg_end_q;
  logic [PW:0] rsum;
  logic [PW-1:0] rend_new;
  logic [7:0] rx_left_q;
  logic final_q;
  logic even_q;
  logic first_q;
  logic bad_q;
  logic bad_now;
  logic rx_last;
  logic [15:0] sw_q;
  logic [15:0] ctrl_sw;
  logic [15:0] din_sw;
  logic [7:0] mem_rdata;
  logic [7:0] resp_byte;
  logic [31:0] rd_val;

  assign PRDATA = prdata_q;
  assign PREADY = pready_q;
  assign PSLVERR = pslverr_q;

  // APB phase decode, one wait state per transfer
  assign access = PSEL & PENABLE & ~pready_q;
  assign wr_fire = PSEL & PENABLE & pready_q & PWRITE;
  assign rd_fire = PSEL & PENABLE & pready_q & ~PWRITE;
  assign ctrl_fire = wr_fire & (PADDR == `FLAC_OFS_CTRL);
  assign din_fire = wr_fire & (PADDR == `FLAC_OFS_DIN);
  assign dout_fire = rd_fire & (PADDR == `FLAC_OFS_DOUT);
  assign c = flac_ctrl_t'(PWDATA);
  assign len_ext = {{(PW-8){1'b0}}, c.len};
  assign role = c.p1[7:5];

  // Selection decode shared by deactivate and activate
  always_comb begin
    sel_ok = (c.p2 == `FLAC_P2_NONE) &&
             (c.p1 == `FLAC_P1_BY_ID || c.p1 == `FLAC_P1_PATH_MF ||
              c.p1 == `FLAC_P1_PATH_DF);
    use_cur = (c.p1 == `FLAC_P1_BY_ID) && (c.len == `FLAC_LEN_NONE);
    tgt = use_cur ? cur_ef_q : file_q.fid;
    file_go = ctrl_fire && (c.op == FLAC_OP_DEACT || c.op == FLAC_OP_ACT) && sel_ok &&
              (!use_cur || cur_valid_q) && file_q.ac_ok;
  end

  // Chain acceptance decode
  always_comb begin
    is_odd = (c.op == FLAC_OP_AUTH_ODD);
    ok_dfirst = is_odd && (role == `FLAC_ROLE_DFIRST) && (c.len != `FLAC_LEN_NONE);
    ok_dnext = is_odd && (role == `FLAC_ROLE_DNEXT) && (c.len != `FLAC_LEN_NONE) &&
               (state_q == FLAC_ST_WAIT);
    ok_dretx = is_odd && (role == `FLAC_ROLE_DRETX) && (c.len != `FLAC_LEN_NONE) &&
               (state_q == FLAC_ST_WAIT || state_q == FLAC_ST_FULL);
    ok_rfirst = is_odd && (role == `FLAC_ROLE_RFIRST) && !even_q &&
                (state_q == FLAC_ST_FULL || state_q == FLAC_ST_RESP);
    ok_rnext = is_odd && (role == `FLAC_ROLE_RNEXT) && (state_q == FLAC_ST_RESP);
    ok_rretx = is_odd && (role == `FLAC_ROLE_RRETX) && (state_q == FLAC_ST_RESP);
    ok_even = (c.op == FLAC_OP_AUTH_EVEN) && (c.p1 == `FLAC_P1_EVEN) &&
              (c.len != `FLAC_LEN_NONE);
    rsum = {1'b0, rseg_end_q} + {1'b0, len_ext};
    if (role == `FLAC_ROLE_RFIRST) begin
      rend_new = (len_ext < total_q) ? len_ext : total_q;
    end else begin
      rend_new = (rsum > {1'b0, total_q}) ? total_q : rsum[PW-1:0];
    end
  end

  // Status word for a control write
  always_comb begin
    case (c.op)
      FLAC_OP_DEACT, FLAC_OP_ACT: begin
        if (!sel_ok) begin
          ctrl_sw = `FLAC_SW_BAD_P1P2;
        end else if (use_cur && !cur_valid_q) begin
          ctrl_sw = `FLAC_SW_SEQ;
        end else if (!file_q.ac_ok) begin
          ctrl_sw = `FLAC_SW_NO_AC;
        end else begin
          ctrl_sw = `FLAC_SW_OK;
        end
      end
      FLAC_OP_AUTH_EVEN: begin
        if (c.p1 != `FLAC_P1_EVEN) begin
          ctrl_sw = `FLAC_SW_BAD_P1P2;
        end else if (c.len == `FLAC_LEN_NONE) begin
          ctrl_sw = `FLAC_SW_BAD_LEN;
        end else begin
          ctrl_sw = `FLAC_SW_PENDING;
        end
      end
      FLAC_OP_AUTH_ODD: begin
        if (role[2:1] == 2'b11) begin
          ctrl_sw = `FLAC_SW_BAD_P1P2;
        end else if (!role[0] && c.len == `FLAC_LEN_NONE) begin
          ctrl_sw = `FLAC_SW_BAD_LEN;
        end else if (ok_dfirst || ok_dnext || ok_dretx) begin
          ctrl_sw = `FLAC_SW_PENDING;
        end else if (ok_rfirst || ok_rnext) begin
          ctrl_sw = (rend_new < total_q) ? `FLAC_SW_MORE_RESP : `FLAC_SW_OK;
        end else if (ok_rretx) begin
          ctrl_sw = (rseg_end_q < total_q) ? `FLAC_SW_MORE_RESP : `FLAC_SW_OK;
        end else begin
          ctrl_sw = `FLAC_SW_SEQ;
        end
      end
      FLAC_OP_FILE_USE: begin
        ctrl_sw = (cur_valid_q && active_q[cur_ef_q[IDX_W-1:0]]) ?
                  `FLAC_SW_OK : `FLAC_SW_INVALID;
      end
      default: begin
        ctrl_sw = `FLAC_SW_BAD_INS;
      end
    endcase
  end

  // Status word when a data block completes
  always_comb begin
    bad_now = bad_q || (first_q && PWDATA[7:0] != `FLAC_TAG_BER &&
                        PWDATA[7:0] != `FLAC_TAG_OTHER);
    rx_last = din_fire && (state_q == FLAC_ST_RX) && (rx_left_q == 8'h01);
    if (bad_now) begin
      din_sw = `FLAC_SW_BAD_TLV;
    end else if (even_q) begin
      din_sw = `FLAC_SW_OK;
    end else if (final_q) begin
      din_sw = `FLAC_SW_DATA_DONE;
    end else begin
      din_sw = `FLAC_SW_MORE_DATA;
    end
  end

  // Register holding the last status word
  always_ff @(posedge CLK_SYS or posedge RST) begin
    if (RST) begin
      sw_q <= `FLAC_SW_RESET;
    end else if (ctrl_fire) begin
      sw_q <= ctrl_sw;
    end else if (rx_last) begin
      sw_q <= din_sw;
    end
  end

  // Software written command and file registers
  always_ff @(posedge CLK_SYS or posedge RST) begin
    if (RST) begin
      ctrl_q <= '0;
      file_q <= '0;
    end else begin
      if (ctrl_fire) begin
        ctrl_q <= c;
      end
      if (wr_fire && PADDR == `FLAC_OFS_FILE) begin
        file_q <= flac_file_t'(PWDATA);
      end
    end
  end

  // Current elementary file tracking
  always_ff @(posedge CLK_SYS or posedge RST) begin
    if (RST) begin
      cur_ef_q <= '0;
      cur_valid_q <= 1'b0;
    end else if (file_go) begin
      cur_ef_q <= tgt;
      cur_valid_q <= 1'b1;
    end
  end

  // Lifecycle flag per file entry, set means active
  for (genvar i = 0; i < NF; i++) begin : g_life
    always_ff @(posedge CLK_SYS or posedge RST) begin
      if (RST) begin
        active_q[i] <= 1'b1;
      end else if (file_go && tgt[IDX_W-1:0] == IDX_W'(i)) begin
        active_q[i] <= (c.op == FLAC_OP_ACT);
      end
    end
  end

  // Authentication chain engine
  always_ff @(posedge CLK_SYS or posedge RST) begin
    if (RST) begin
      state_q <= FLAC_ST_IDLE;
      wptr_q <= '0;
      seg_start_q <= '0;
      total_q <= '0;
      rptr_q <= '0;
      rseg_start_q <= '0;
      rseg_end_q <= '0;
      rx_left_q <= '0;
      final_q <= 1'b0;
      even_q <= 1'b0;
      first_q <= 1'b0;
      bad_q <= 1'b0;
    end else if (ctrl_fire) begin
      if (ok_dfirst || ok_even) begin
        wptr_q <= '0;
        seg_start_q <= '0;
        rx_left_q <= c.len;
        final_q <= ok_even | c.final_seg;
        even_q <= ok_even;
        first_q <= ok_dfirst;
        bad_q <= 1'b0;
        state_q <= FLAC_ST_RX;
      end else if (ok_dnext) begin
        seg_start_q <= wptr_q;
        rx_left_q <= c.len;
        final_q <= c.final_seg;
        state_q <= FLAC_ST_RX;
      end else if (ok_dretx) begin
        wptr_q <= seg_start_q;
        rx_left_q <= c.len;
        final_q <= c.final_seg;
        first_q <= (seg_start_q == '0);
        bad_q <= (seg_start_q == '0) ? 1'b0 : bad_q;
        state_q <= FLAC_ST_RX;
      end else if (ok_rfirst) begin
        rptr_q <= '0;
        rseg_start_q <= '0;
        rseg_end_q <= rend_new;
        state_q <= FLAC_ST_RESP;
      end else if (ok_rnext) begin
        rptr_q <= rseg_end_q;
        rseg_start_q <= rseg_end_q;
        rseg_end_q <= rend_new;
      end else if (ok_rretx) begin
        rptr_q <= rseg_start_q;
      end
    end else if (din_fire && state_q == FLAC_ST_RX) begin
      wptr_q <= wptr_q + PW'(1);
      rx_left_q <= rx_left_q - 8'h01;
      first_q <= 1'b0;
      bad_q <= bad_now;
      if (rx_left_q == 8'h01) begin
        if (bad_now) begin
          state_q <= FLAC_ST_IDLE;
        end else if (even_q) begin
          total_q <= wptr_q + PW'(1);
          rptr_q <= '0;
          rseg_start_q <= '0;
          rseg_end_q <= wptr_q + PW'(1);
          state_q <= FLAC_ST_RESP;
        end else if (final_q) begin
          total_q <= wptr_q + PW'(1);
          state_q <= FLAC_ST_FULL;
        end else begin
          state_q <= FLAC_ST_WAIT;
        end
      end
    end else if (dout_fire && state_q == FLAC_ST_RESP && rptr_q < rseg_end_q) begin
      rptr_q <= rptr_q + PW'(1);
    end
  end

  // Joined data store, read at the response pointer
  flac_buf #(
    .DW(8),
    .AW(BUF_AW)
  ) u_buf (
    .clk(CLK_SYS),
    .we(din_fire && state_q == FLAC_ST_RX),
    .waddr(wptr_q[BUF_AW-1:0]),
    .wdata(PWDATA[7:0]),
    .raddr(rptr_q[BUF_AW-1:0]),
    .rdata_q(mem_rdata)
  );

  // Response byte: odd form keeps the wrapper header raw
  always_comb begin
    if (state_q != FLAC_ST_RESP || rptr_q >= rseg_end_q) begin
      resp_byte = 8'h00;
    end else if (!even_q && rptr_q < PW'(`FLAC_TLV_HDR)) begin
      resp_byte = mem_rdata;
    end else begin
      resp_byte = mem_rdata ^ SECRET;
    end
  end

  // Read mux and address map
  always_comb begin
    mapped = 1'b1;
    case (PADDR)
      `FLAC_OFS_CTRL: rd_val = ctrl_q;
      `FLAC_OFS_FILE: rd_val = file_q;
      `FLAC_OFS_DIN: rd_val = 32'h0000_0000;
      `FLAC_OFS_DOUT: rd_val = {24'h00_0000, resp_byte};
      `FLAC_OFS_STAT: rd_val = {(state_q == FLAC_ST_RX), 4'h0, rx_left_q,
                                state_q, sw_q};
      `FLAC_OFS_CUR: rd_val = {cur_valid_q, active_q[cur_ef_q[IDX_W-1:0]], 14'h0000,
                               cur_ef_q};
      default: begin
        rd_val = 32'h0000_0000;
        mapped = 1'b0;
      end
    endcase
  end

  // APB answer registers
  always_ff @(posedge CLK_SYS or posedge RST) begin
    if (RST) begin
      pready_q <= 1'b0;
      pslverr_q <= 1'b0;
      prdata_q <= '0;
    end else begin
      pready_q <= access;
      pslverr_q <= access & ~mapped;
      prdata_q <= (access & ~PWRITE) ? rd_val : 32'h0000_0000;
    end
  end
endmodule // flac_core

// File: rtl/flac_defs.svh
// Constant macros for the file lifecycle and authenticate chaining block
`ifndef FLAC_DEFS_SVH
`define FLAC_DEFS_SVH
// APB byte offsets
`define FLAC_OFS_CTRL 8'h00
`define FLAC_OFS_FILE 8'h04
`define FLAC_OFS_DIN 8'h08
`define FLAC_OFS_DOUT 8'h0c
`define FLAC_OFS_STAT 8'h10
`define FLAC_OFS_CUR 8'h14
// Status words
`define FLAC_SW_RESET 16'h9000
`define FLAC_SW_OK 16'h9000
`define FLAC_SW_PENDING 16'h0000
`define FLAC_SW_MORE_DATA 16'h63f1
`define FLAC_SW_DATA_DONE 16'h62f3
`define FLAC_SW_MORE_RESP 16'h62f1
`define FLAC_SW_BAD_P1P2 16'h6a86
`define FLAC_SW_NO_AC 16'h6982
`define FLAC_SW_SEQ 16'h6985
`define FLAC_SW_BAD_TLV 16'h6a80
`define FLAC_SW_BAD_LEN 16'h6700
`define FLAC_SW_INVALID 16'h6283
`define FLAC_SW_BAD_INS 16'h6d00
// File selection codes
`define FLAC_P1_BY_ID 8'h00
`define FLAC_P1_PATH_MF 8'h08
`define FLAC_P1_PATH_DF 8'h09
`define FLAC_P2_NONE 8'h00
`define FLAC_LEN_NONE 8'h00
`define FLAC_P1_EVEN 8'h00
// Block roles in the upper three bits of P1
`define FLAC_ROLE_DFIRST 3'b100
`define FLAC_ROLE_DNEXT 3'b000
`define FLAC_ROLE_DRETX 3'b010
`define FLAC_ROLE_RFIRST 3'b101
`define FLAC_ROLE_RNEXT 3'b001
`define FLAC_ROLE_RRETX 3'b011
// Wrapper tags and header bytes kept raw in the response
`define FLAC_TAG_BER 8'h73
`define FLAC_TAG_OTHER 8'h53
`define FLAC_TLV_HDR 2
`endif

// File: rtl/flac_pkg.sv
// Types for the file lifecycle and authenticate chaining block
package flac_pkg;
  typedef enum logic [2:0] {
    FLAC_OP_DEACT = 3'b000,
    FLAC_OP_ACT = 3'b001,
    FLAC_OP_AUTH_EVEN = 3'b010,
    FLAC_OP_AUTH_ODD = 3'b011,
    FLAC_OP_FILE_USE = 3'b100
  } flac_op_t;

  typedef enum logic [2:0] {
    FLAC_ST_IDLE = 3'b000,
    FLAC_ST_RX = 3'b001,
    FLAC_ST_WAIT = 3'b010,
    FLAC_ST_FULL = 3'b011,
    FLAC_ST_RESP = 3'b100
  } flac_state_t;

  typedef struct packed {
    logic [3:0] spare;
    logic final_seg;
    flac_op_t op;
    logic [7:0] len;
    logic [7:0] p2;
    logic [7:0] p1;
  } flac_ctrl_t;

  typedef struct packed {
    logic [14:0] spare;
    logic ac_ok;
    logic [15:0] fid;
  } flac_file_t;
endpackage
